// *** design/uerr_pkg.sv ***
// package: offsets, field positions, reset values for the uncorrectable error status/mask bank
// assumes: classic wishbone slave with 32-bit data, byte addresses
package uerr_pkg;
	localparam logic [11:0] STATUS_OFS   = 12'h0104;
	localparam logic [11:0] MASK_OFS     = 12'h0108;
	localparam logic [11:0] CTRL_OFS     = 12'h0200;
	localparam logic [11:0] IRQ_STAT_OFS = 12'h0210;
	localparam logic [11:0] IRQ_EN_OFS   = 12'h0214;
	localparam logic [11:0] IRQ_CLR_OFS  = 12'h0218;
	localparam logic [11:0] LOG_OFS      = 12'h021C;
	localparam int BIT_UNUSED    = 0;
	localparam int BIT_LINKPROTO = 4;
	localparam int BIT_SURPRISE  = 5;
	localparam int BIT_POISON    = 12;
	localparam int BIT_MCBLK     = 23;
	localparam int BIT_ATOMIC    = 24;
	localparam int BIT_PREFIX    = 25;
	localparam int CTRL_MCDIS    = 0;
	localparam int CTRL_UPSTREAM = 1;
	localparam logic [4:0] FEP_NONE = 5'h1F;
	localparam logic [31:0] MASK_WR_BITS  = 32'h0000_1031;
	localparam logic [31:0] STAT_EVT_BITS = 32'h0080_1030;
	localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
	localparam logic [31:0] RESET_WORD    = 32'h0000_0000;
	localparam logic [3:0]  IRQ_RESET     = 4'h0;
	localparam int IRQ_N = 4;
	localparam int IRQ_MC = 0;
	localparam int IRQ_LP = 1;
	localparam int IRQ_SD = 2;
	localparam int IRQ_PO = 3;
	localparam logic [31:0] DEAD_READ = 32'hDEAD_0000;
endpackage : uerr_pkg

// *** design/uerr_evt_if.sv ***
// interface: error events and report strobes between the bank and the report logic
// assumes: one clock domain, pulses one cycle wide
`timescale 1ns/10ps
interface uerr_evt_if;
	logic [31:0] evt;
	logic [31:0] mask;
	logic [31:0] fresh;
	logic        rep_valid;
	logic [4:0]  rep_bit;
	modport bank (output evt, output mask, input fresh, input rep_valid, input rep_bit);
	modport rep  (input evt, input mask, output fresh, output rep_valid, output rep_bit);
endinterface : uerr_evt_if

// *** design/uerr_report.sv ***
// module: decides which unmasked events are logged, reported and update the first error pointer
// assumes: events are one-cycle pulses on ref_clk
`timescale 1ns/10ps
module uerr_report
	import uerr_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic arst_n,
	uerr_evt_if.rep   ev
);
	logic [31:0] live;
	logic [4:0]  low_bit;

	function automatic logic [4:0] lowest(input logic [31:0] v);
		lowest = FEP_NONE;
		for (int i = 31; i >= 0; i--) begin
			if (v[i]) begin
				lowest = 5'(i);
			end
		end
	endfunction : lowest

	assign live    = ev.evt & ~ev.mask;  // masked events are never logged
	assign low_bit = lowest(live);
	assign ev.fresh = live;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ev.rep_valid <= 1'b0;
			ev.rep_bit   <= FEP_NONE;
		end else begin
			ev.rep_valid <= |live;  // no report to the root complex when masked
			ev.rep_bit   <= low_bit;
		end
	end
endmodule : uerr_report

// *** design/uerr_bank.sv ***
// top: uncorrectable error status and mask registers behind a classic wishbone slave
// assumes: single clock, events are one-cycle pulses, reset is the sticky-domain reset
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/10ps
module uerr_bank
	import uerr_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [11:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	output logic             wb_err_o,
	input  wire logic        multicast_block_everything,
	input  wire logic        multicast_block_untranslated_ctl,
	input  wire logic        mc_drop_pulse,
	input  wire logic        link_protocol_err_pulse,
	input  wire logic        surprise_down_pulse,
	input  wire logic        poisoned_pulse,
	output logic             report_valid,
	output logic [4:0]       first_error_pointer,
	output logic             log_valid,
	output logic             irq
);
	////////////////////////////////////////////////////////////////
	uerr_evt_if ev ();
	uerr_report u_report (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.ev      (ev)
	);

	logic [31:0] status_r;
	logic [31:0] mask_r;
	logic [1:0]  ctrl_r;
	logic [3:0]  irq_stat_r;
	logic [3:0]  irq_en_r;
	logic [31:0] log_r;
	logic [31:0] wmask;
	logic        req;
	logic        wr;
	logic        hit;
	logic        mc_evt;
	logic [31:0] evt;
	logic [31:0] status_view;
	logic [31:0] rd_nxt;
	logic [3:0]  irq_evt;

	function automatic logic [31:0] lane_mask(input logic [3:0] sel);
		lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction : lane_mask

	////////////////////////////////////////////////////////////////
	assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	assign wr    = req & wb_we_i;
	assign wmask = lane_mask(wb_sel_i) & wb_dat_i;
	assign hit   = (wb_adr_i == STATUS_OFS) | (wb_adr_i == MASK_OFS) | (wb_adr_i == CTRL_OFS)
		| (wb_adr_i == IRQ_STAT_OFS) | (wb_adr_i == IRQ_EN_OFS) | (wb_adr_i == IRQ_CLR_OFS)
		| (wb_adr_i == LOG_OFS);

	// a drop only counts when one of the block controls caused it
	assign mc_evt = mc_drop_pulse & (multicast_block_everything | multicast_block_untranslated_ctl)
		& ~ctrl_r[CTRL_MCDIS];

	always_comb begin
		evt = ZERO_WORD;
		evt[BIT_MCBLK]     = mc_evt;
		evt[BIT_LINKPROTO] = link_protocol_err_pulse;
		evt[BIT_POISON]    = poisoned_pulse;
		evt[BIT_SURPRISE]  = surprise_down_pulse & ~ctrl_r[CTRL_UPSTREAM];
	end

	assign ev.evt  = evt;
	assign ev.mask = mask_r & ~(32'h1 << BIT_UNUSED);  // bit 0 has no effect on handling

	////////////////////////////////////////////////////////////////
	// status: hardware set wins over software clear; mask not consulted here
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			status_r <= RESET_WORD;
		end else begin
			logic [31:0] clr;
			clr = (wr && wb_adr_i == STATUS_OFS) ? wmask : ZERO_WORD;
			status_r <= ((status_r & ~clr) | evt) & STAT_EVT_BITS;
			if (ctrl_r[CTRL_MCDIS]) begin
				status_r[BIT_MCBLK] <= 1'b0;
			end
		end
	end

	// read view keeps fixed-zero fields zero
	always_comb begin
		status_view = status_r & STAT_EVT_BITS;
		status_view[BIT_ATOMIC] = 1'b0;
		status_view[BIT_PREFIX] = 1'b0;
		if (ctrl_r[CTRL_MCDIS]) begin
			status_view[BIT_MCBLK] = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			mask_r <= RESET_WORD;
		end else if (wr && wb_adr_i == MASK_OFS) begin
			logic [31:0] keep;
			keep = lane_mask(wb_sel_i) & MASK_WR_BITS;
			if (ctrl_r[CTRL_UPSTREAM]) begin
				keep[BIT_SURPRISE] = 1'b0;
			end else begin
				keep[BIT_SURPRISE] = wb_sel_i[0];
			end
			mask_r <= (mask_r & ~keep) | (wb_dat_i & keep);
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_r <= 2'b00;
		end else if (wr && wb_adr_i == CTRL_OFS && wb_sel_i[0]) begin
			ctrl_r <= wb_dat_i[1:0];
		end
	end

	////////////////////////////////////////////////////////////////
	// first error pointer and log follow only unmasked events
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			first_error_pointer <= FEP_NONE;
			log_r               <= ZERO_WORD;
			report_valid        <= 1'b0;
			log_valid           <= 1'b0;
		end else begin
			report_valid <= ev.rep_valid;
			log_valid    <= |ev.fresh;
			log_r        <= log_r | ev.fresh;
			if (ev.rep_valid && first_error_pointer == FEP_NONE) begin
				first_error_pointer <= ev.rep_bit;
			end
			if (wr && wb_adr_i == LOG_OFS && wb_sel_i[0]) begin
				log_r               <= ZERO_WORD;
				first_error_pointer <= FEP_NONE;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	assign irq_evt = {evt[BIT_POISON], evt[BIT_SURPRISE], evt[BIT_LINKPROTO], evt[BIT_MCBLK]};

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_stat_r <= IRQ_RESET;
		end else begin
			logic [3:0] c;
			c = (wr && wb_adr_i == IRQ_CLR_OFS && wb_sel_i[0]) ? wb_dat_i[3:0] : IRQ_RESET;
			irq_stat_r <= (irq_stat_r & ~c) | irq_evt;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_en_r <= IRQ_RESET;
		end else if (wr && wb_adr_i == IRQ_EN_OFS && wb_sel_i[0]) begin
			irq_en_r <= wb_dat_i[3:0];
		end
	end

	assign irq = |(irq_stat_r & irq_en_r);

	////////////////////////////////////////////////////////////////
	always_comb begin
		rd_nxt = ZERO_WORD;
		case (wb_adr_i)
			STATUS_OFS:   rd_nxt = status_view;
			MASK_OFS:     rd_nxt = mask_r & MASK_WR_BITS;
			CTRL_OFS:     rd_nxt = {30'h0, ctrl_r};
			IRQ_STAT_OFS: rd_nxt = {28'h0, irq_stat_r};
			IRQ_EN_OFS:   rd_nxt = {28'h0, irq_en_r};
			LOG_OFS:      rd_nxt = {log_r[31:8] & 24'hFF_FFFF, 3'b000, first_error_pointer} | (log_r & 32'h0000_0000);
			default:      rd_nxt = ZERO_WORD;
		endcase
	end

	// one wait state: ack or err one edge after the request is seen, dropped the next
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= ZERO_WORD;
		end else begin
			wb_ack_o <= req & hit;
			wb_err_o <= req & ~hit;
			wb_dat_o <= (req && hit && !wb_we_i) ? rd_nxt : ZERO_WORD;
		end
	end
endmodule : uerr_bank

// *** bench/uerr_bank_monitor.sv ***
// checker: bus answer and report timing of the error bank
// assumes: bound to uerr_bank, single clock
`timescale 1ns/10ps
module uerr_bank_monitor
	import uerr_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        arst_n,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        wb_err_o,
	input wire logic        mc_drop_pulse,
	input wire logic        link_protocol_err_pulse,
	input wire logic        surprise_down_pulse,
	input wire logic        poisoned_pulse,
	input wire logic        report_valid,
	input wire logic [4:0]  first_error_pointer,
	input wire logic        log_valid
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	logic rd_s;
	logic rd_m;
	logic any_evt;
	assign rd_s = wb_ack_o && !wb_we_i && wb_adr_i == STATUS_OFS;
	assign rd_m = wb_ack_o && !wb_we_i && wb_adr_i == MASK_OFS;
	assign any_evt = mc_drop_pulse | link_protocol_err_pulse | surprise_down_pulse | poisoned_pulse;
	property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
	property p_answer; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o; endproperty
	a_answer: assert property (p_answer) else $error("request not answered in one cycle");
	property p_idle_dat; !wb_ack_o |-> wb_dat_o == ZERO_WORD; endproperty
	a_idle_dat: assert property (p_idle_dat) else $error("read data outside ack");
	property p_fixed_zero; rd_s |-> wb_dat_o[31:24] == 8'h00; endproperty
	a_fixed_zero: assert property (p_fixed_zero) else $error("status bits 31:24 not zero");
	property p_mask_rsv; rd_m |-> (wb_dat_o & ~MASK_WR_BITS) == ZERO_WORD; endproperty
	a_mask_rsv: assert property (p_mask_rsv) else $error("reserved mask bit set");
	property p_log_cause; log_valid |-> $past(any_evt); endproperty
	a_log_cause: assert property (p_log_cause) else $error("log without event");
	property p_log_rep; log_valid |=> report_valid; endproperty
	a_log_rep: assert property (p_log_rep) else $error("logged error not reported");
	property p_fep_hold;
		$changed(first_error_pointer) |-> report_valid || (wb_ack_o && wb_we_i && wb_adr_i == LOG_OFS);
	endproperty
	a_fep_hold: assert property (p_fep_hold) else $error("pointer moved without report");
endmodule : uerr_bank_monitor
bind uerr_bank uerr_bank_monitor u_mon (.*);

// *** bench/rc_model.sv ***
// model: root complex side, counts reports and logs, keeps last pointer
// assumes: report_valid and log_valid are one-cycle pulses
`timescale 1ns/10ps
module rc_model (
	input wire logic       ref_clk,
	input wire logic       arst_n,
	input wire logic       report_valid,
	input wire logic       log_valid,
	input wire logic [4:0] first_error_pointer
);
	int         reports;
	int         logs;
	logic [4:0] last_ptr;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			reports <= 0;
			logs <= 0;
			last_ptr <= 5'h1F;
		end else begin
			if (report_valid) reports <= reports + 1;
			if (report_valid) last_ptr <= first_error_pointer;
			if (log_valid) logs <= logs + 1;
		end
	end
endmodule : rc_model

// *** bench/tb_uerr_bank.sv ***
// testbench: register, event, mask and interrupt scenarios of the error bank
// assumes: one 25 MHz clock, wishbone answer one cycle after take
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; $display("FAIL %0t mismatch", $time); end end
module tb_uerr_bank
	import uerr_pkg::*;
;
	logic        ref_clk, arst_n, cyc, stb, we, ack, err, blk_all, blk_unt, rep, lv, irq, last_err;
	logic [11:0] adr;
	logic [3:0]  sel, ev;
	logic [31:0] dat_i, dat_o, q;
	logic [4:0]  fep;
	int          err_count, tests_run;
	uerr_bank uut (.ref_clk(ref_clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err),
		.multicast_block_everything(blk_all), .multicast_block_untranslated_ctl(blk_unt),
		.mc_drop_pulse(ev[0]), .link_protocol_err_pulse(ev[1]), .surprise_down_pulse(ev[2]),
		.poisoned_pulse(ev[3]), .report_valid(rep), .first_error_pointer(fep), .log_valid(lv), .irq(irq));
	rc_model rc (.ref_clk(ref_clk), .arst_n(arst_n), .report_valid(rep), .log_valid(lv),
		.first_error_pointer(fep));
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	task summarize;
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : summarize
	// holds the request until ack or err is sampled, then releases
	task wb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_i <= d;
		do @(posedge ref_clk); while (!(ack || err));
		q = dat_o;
		last_err = err;
		cyc <= 1'b0; stb <= 1'b0;
	endtask : wb
	task evt(input int k);
		@(posedge ref_clk); ev[k] <= 1'b1;
		@(posedge ref_clk); ev <= 4'h0;
		repeat (4) @(posedge ref_clk);
	endtask : evt
	task t_reset;
		wb(1'b0, STATUS_OFS, ZERO_WORD); `CHK(q, RESET_WORD)
		wb(1'b0, MASK_OFS, ZERO_WORD); `CHK(q, RESET_WORD)
		`CHK(fep, FEP_NONE)
	endtask : t_reset
	task t_masked;
		wb(1'b1, MASK_OFS, 32'hFFFF_FFFF); wb(1'b0, MASK_OFS, ZERO_WORD);
		`CHK(q, MASK_WR_BITS)
		evt(3); wb(1'b0, STATUS_OFS, ZERO_WORD); `CHK(q[BIT_POISON], 1'b1)
		`CHK(rc.logs, 0)
		`CHK(rc.reports, 0)
		`CHK(fep, FEP_NONE)
	endtask : t_masked
	task t_unmasked;
		wb(1'b1, MASK_OFS, ZERO_WORD); evt(1);
		wb(1'b0, STATUS_OFS, ZERO_WORD); `CHK(q[BIT_LINKPROTO], 1'b1)
		`CHK(rc.reports, 1)
		`CHK(rc.logs, 1)
		`CHK(rc.last_ptr, 5'(BIT_LINKPROTO))
		wb(1'b1, STATUS_OFS, 32'h0000_1010); wb(1'b0, STATUS_OFS, ZERO_WORD); `CHK(q, ZERO_WORD)
	endtask : t_unmasked
	task t_multicast;
		blk_all <= 1'b1; evt(0);
		wb(1'b0, STATUS_OFS, ZERO_WORD); `CHK(q[BIT_MCBLK], 1'b1)
		wb(1'b1, STATUS_OFS, 32'h0080_0000);
		wb(1'b0, STATUS_OFS, ZERO_WORD); `CHK(q[BIT_MCBLK], 1'b0)
		evt(0);
		wb(1'b1, IRQ_EN_OFS, 32'h0000_0001); @(negedge ref_clk); `CHK(irq, 1'b1)
		wb(1'b1, IRQ_CLR_OFS, 32'h0000_000F); @(negedge ref_clk); `CHK(irq, 1'b0)
		wb(1'b1, CTRL_OFS, 32'h0000_0001); wb(1'b0, STATUS_OFS, ZERO_WORD); `CHK(q[BIT_MCBLK], 1'b0)
		evt(0); wb(1'b0, STATUS_OFS, ZERO_WORD); `CHK(q[BIT_MCBLK], 1'b0)
		wb(1'b1, CTRL_OFS, ZERO_WORD);
		blk_all <= 1'b0; blk_unt <= 1'b1; evt(0);
		wb(1'b0, STATUS_OFS, ZERO_WORD); `CHK(q[BIT_MCBLK], 1'b1)
		wb(1'b1, IRQ_EN_OFS, ZERO_WORD); @(negedge ref_clk); `CHK(irq, 1'b0)
	endtask : t_multicast
	task t_upstream;
		wb(1'b1, CTRL_OFS, 32'h0000_0002); wb(1'b1, MASK_OFS, 32'h0000_0020);
		wb(1'b0, MASK_OFS, ZERO_WORD); `CHK(q, ZERO_WORD)
		wb(1'b0, 12'h0FFC, ZERO_WORD); `CHK(last_err, 1'b1)
	endtask : t_upstream
	// the whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge ref_clk);
		err_count++;
		summarize();
	end
	initial begin
		arst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 12'h000; sel = 4'hF; dat_i = ZERO_WORD;
		ev = 4'h0; blk_all = 1'b0; blk_unt = 1'b0; err_count = 0; tests_run = 0;
		repeat (20) @(posedge ref_clk);
		arst_n <= 1'b1;
		t_reset(); t_masked(); t_unmasked(); t_multicast(); t_upstream();
		summarize();
	end
endmodule : tb_uerr_bank
